// ==== logic/input_capture_control.v ====
`timescale 1ns/1ns
`include "capture_regs.vh"

// Functional notes
// - Enable clear resets channel, blocks interrupts
// - Idle-halt bit stops channel during idle
// - Mode 6 first edge per select bit
// - Wide select captures 32-bit timer value
// - Timebase select picks counter in 16-bit
// - Interrupt every one to four captures
// - Read-only overflow flag set on overflow
// - Read-only buffer-not-empty flag
// - Unimplemented bits read zero; reset zero
module input_capture_control (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [31:0] reg_rdata,
  // Capture pin and system state
  input  wire        capture_pin,
  input  wire        idle_mode,
  // Timebases
  input  wire [15:0] first_timebase,
  input  wire [15:0] second_timebase,
  input  wire [31:0] wide_timebase,
  // Interrupt
  output reg         irq
);
  // ==========================================================
  // Registers
  reg [31:0] control_reg;
  reg        overflow_reg;
  reg [1:0]  event_count_reg;
  reg        alt_phase_reg;
  reg [3:0]  prescale_reg;
  reg [1:0]  irq_status_reg;
  reg [1:0]  irq_enable_reg;

  wire       enable     = control_reg[`BIT_ENABLE];
  wire       idle_halt  = control_reg[`BIT_IDLE_HALT];
  wire       first_edge = control_reg[`BIT_FIRST_EDGE];
  wire       wide       = control_reg[`BIT_WIDE];
  wire       timebase   = control_reg[`BIT_TIMEBASE];
  wire [1:0] per_irq    = control_reg[`BIT_EPI_HI:`BIT_EPI_LO];
  wire [2:0] mode       = control_reg[`BIT_MODE_HI:`BIT_MODE_LO];

  // Channel runs only when enabled and not parked by idle
  wire running = enable && !(idle_halt && idle_mode);

  // ==========================================================
  // Edge detection
  wire rise;
  wire fall;

  edge_detect pin_edges (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .level_in (capture_pin),
    .rise     (rise),
    .fall     (fall)
  );

  // ==========================================================
  // Event qualification by mode
  reg capture_event;
  always @* begin
    capture_event = 1'b0;
    case (mode)
      `MODE_OFF:        capture_event = 1'b0;
      `MODE_EVERY_EDGE: capture_event = rise || fall;
      `MODE_FALL:       capture_event = fall;
      `MODE_RISE:       capture_event = rise;
      `MODE_RISE_4TH:   capture_event = rise && (prescale_reg[1:0] == 2'h3);
      `MODE_RISE_16TH:  capture_event = rise && (prescale_reg == 4'hf);
      // Alternate: first edge chosen by select bit, then toggle
      `MODE_ALTERNATE:  capture_event = alt_phase_reg ? (first_edge ? fall : rise)
                                                      : (first_edge ? rise : fall);
      `MODE_RISE_ALT:   capture_event = rise;
      default:          capture_event = 1'b0;
    endcase
    capture_event = capture_event && running;
  end

  // Prescaler and alternating phase; cleared while disabled
  always @(posedge ref_clk) begin
    if (rst || !enable) begin
      prescale_reg  <= 4'h0;
      alt_phase_reg <= 1'b0;
    end else if (running) begin
      if (rise && (mode == `MODE_RISE_4TH || mode == `MODE_RISE_16TH))
        prescale_reg <= prescale_reg + 4'h1;
      if (mode == `MODE_ALTERNATE && capture_event)
        alt_phase_reg <= !alt_phase_reg;
    end
  end

  // ==========================================================
  // Timer value selection
  wire [31:0] capture_value = wide ? wide_timebase
                                   : {16'h0000, timebase ? first_timebase : second_timebase};

  // ==========================================================
  // Capture buffer
  wire        buf_full;
  wire        buf_empty;
  wire [31:0] buf_data;
  wire        buf_pop = reg_read && (reg_addr == `OFS_BUFFER);

  capture_buffer fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .flush     (!enable),
    .push      (capture_event),
    .push_data (capture_value),
    .pop       (buf_pop),
    .pop_data  (buf_data),
    .full      (buf_full),
    .empty     (buf_empty)
  );

  wire overflow_event = capture_event && buf_full;

  // Overflow flag: set on capture into a full buffer, cleared by disable
  always @(posedge ref_clk) begin
    if (rst || !enable) begin
      overflow_reg <= 1'b0;
    end else if (overflow_event) begin
      overflow_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Interrupt decimation: one pulse every N captures
  wire n_reached = (event_count_reg == per_irq);
  wire irq_event = capture_event && !buf_full && n_reached;

  always @(posedge ref_clk) begin
    if (rst || !enable) begin
      event_count_reg <= 2'h0;
    end else if (capture_event && !buf_full) begin
      event_count_reg <= n_reached ? 2'h0 : event_count_reg + 2'h1;
    end
  end

  // ==========================================================
  // Control register write; read-only flags never stored
  always @(posedge ref_clk) begin
    if (rst) begin
      control_reg <= `CONTROL_RESET;
    end else if (reg_write && reg_addr == `OFS_CONTROL) begin
      control_reg <= reg_wdata & `CONTROL_RW_MASK;
    end
  end

  // Interrupt enable
  always @(posedge ref_clk) begin
    if (rst) begin
      irq_enable_reg <= 2'h0;
    end else if (reg_write && reg_addr == `OFS_IRQ_ENABLE) begin
      irq_enable_reg <= reg_wdata[1:0];
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  reg [1:0] irq_status_next;
  always @* begin
    irq_status_next = irq_status_reg;
    if (reg_write && reg_addr == `OFS_IRQ_CLEAR)
      irq_status_next = irq_status_next & ~reg_wdata[1:0];
    if (irq_event)
      irq_status_next[`IRQ_CAPTURE] = 1'b1;
    if (overflow_event)
      irq_status_next[`IRQ_OVERFLOW] = 1'b1;
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      irq_status_reg <= 2'h0;
      irq            <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      // Disabled channel raises no interrupt
      irq            <= enable && |(irq_status_next & irq_enable_reg);
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe; buffer word comes from the FIFO
  reg        read_buf_reg;
  reg [31:0] read_word_reg;
  always @(posedge ref_clk) begin
    if (rst) begin
      read_buf_reg  <= 1'b0;
      read_word_reg <= 32'h00000000;
    end else begin
      read_buf_reg  <= buf_pop;
      read_word_reg <= 32'h00000000;
      if (reg_read) begin
        case (reg_addr)
          `OFS_CONTROL: read_word_reg <= control_reg
                                       | ({31'h0, overflow_reg} << `BIT_OVERFLOW)
                                       | ({31'h0, !buf_empty} << `BIT_NOT_EMPTY);
          `OFS_IRQ_STATUS: read_word_reg <= {30'h0, irq_status_reg};
          `OFS_IRQ_ENABLE: read_word_reg <= {30'h0, irq_enable_reg};
          default:         read_word_reg <= 32'h00000000;
        endcase
      end
    end
  end

  always @* begin
    reg_rdata = read_buf_reg ? buf_data : read_word_reg;
  end
endmodule // input_capture_control

// ==== logic/capture_regs.vh ====
`ifndef CAPTURE_REGS_VH
`define CAPTURE_REGS_VH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define OFS_CONTROL      8'h00
`define OFS_BUFFER       8'h04
`define OFS_IRQ_STATUS   8'h08
`define OFS_IRQ_ENABLE   8'h0c
`define OFS_IRQ_CLEAR    8'h10

// ==========================================================
// Control register fields
`define BIT_ENABLE       15
`define BIT_IDLE_HALT    13
`define BIT_FIRST_EDGE   9
`define BIT_WIDE         8
`define BIT_TIMEBASE     7
`define BIT_EPI_HI       6
`define BIT_EPI_LO       5
`define BIT_OVERFLOW     4
`define BIT_NOT_EMPTY    3
`define BIT_MODE_HI      2
`define BIT_MODE_LO      0
`define CONTROL_RW_MASK  32'h0000a3e7
`define CONTROL_RESET    32'h00000000

// ==========================================================
// Capture modes
`define MODE_OFF         3'h0
`define MODE_EVERY_EDGE  3'h1
`define MODE_FALL        3'h2
`define MODE_RISE        3'h3
`define MODE_RISE_4TH    3'h4
`define MODE_RISE_16TH   3'h5
`define MODE_ALTERNATE   3'h6
`define MODE_RISE_ALT    3'h7

// ==========================================================
// Interrupt status bits
`define IRQ_CAPTURE      0
`define IRQ_OVERFLOW     1

// ==========================================================
// Buffer geometry
`define BUF_DEPTH        4
`define BUF_AW           2

`endif

// ==== logic/capture_buffer.v ====
`timescale 1ns/1ns
// ==========================================================
// Capture buffer: small FIFO, registered read data
module capture_buffer (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Flush while disabled
  input  wire        flush,
  // Write side
  input  wire        push,
  input  wire [31:0] push_data,
  // Read side
  input  wire        pop,
  output reg  [31:0] pop_data,
  output wire        full,
  output wire        empty
);
  reg [31:0] mem [0:3];
  reg [1:0]  wr_ptr_reg;
  reg [1:0]  rd_ptr_reg;
  reg [2:0]  count_reg;

  assign full  = (count_reg == 3'h4);
  assign empty = (count_reg == 3'h0);

  // Pointers and count; push when full is dropped here
  always @(posedge ref_clk) begin
    if (rst || flush) begin
      wr_ptr_reg <= 2'h0;
      rd_ptr_reg <= 2'h0;
      count_reg  <= 3'h0;
      pop_data   <= 32'h00000000;
    end else begin
      if (push && !full) begin
        mem[wr_ptr_reg] <= push_data;
        wr_ptr_reg      <= wr_ptr_reg + 2'h1;
      end
      if (pop && !empty) begin
        pop_data   <= mem[rd_ptr_reg];
        rd_ptr_reg <= rd_ptr_reg + 2'h1;
      end else if (pop) begin
        pop_data <= 32'h00000000;
      end
      count_reg <= count_reg + {2'h0, push && !full} - {2'h0, pop && !empty};
    end
  end
endmodule // capture_buffer

// ==== logic/edge_detect.v ====
`timescale 1ns/1ns
// ==========================================================
// Edge detector on a synchronous input
module edge_detect (
  // Clock and reset
  input  wire ref_clk,
  input  wire rst,
  // Pin and edges
  input  wire level_in,
  output wire rise,
  output wire fall
);
  reg last_reg;

  // Remember last level; input already synchronous
  always @(posedge ref_clk) begin
    if (rst) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= level_in;
    end
  end

  assign rise = level_in && !last_reg;
  assign fall = !level_in && last_reg;
endmodule // edge_detect

// ==== verification/capture_source.sv ====
`timescale 1ns/1ns
// ==========================================================
// Far side: capture pin and three timebase counters
module capture_source (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Bench commands
  input  wire        tick,
  input  wire        toggle,
  // Pin and timebases
  output reg         capture_pin,
  output reg  [15:0] first_timebase,
  output reg  [15:0] second_timebase,
  output reg  [31:0] wide_timebase
);
  // Unequal steps, so a capture from the wrong source shows
  always @(posedge ref_clk) begin
    if (rst) begin
      capture_pin     <= 1'b0;
      first_timebase  <= 16'h0000;
      second_timebase <= 16'h0000;
      wide_timebase   <= 32'h00000000;
    end else begin
      if (tick) begin
        first_timebase  <= first_timebase + 16'h0001;
        second_timebase <= second_timebase + 16'h0002;
        wide_timebase   <= wide_timebase + 32'h00010003;
      end
      if (toggle) begin
        capture_pin <= ~capture_pin;
      end
    end
  end
endmodule // capture_source

// ==== verification/capture_checker.sv ====
`timescale 1ns/1ns
// ==========================================================
// Port checker for the capture channel
module capture_checker (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst,
  // Register port
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_write,
  input wire        reg_read,
  input wire [31:0] reg_rdata,
  // Interrupt
  input wire        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Reads and reset
  reset_quiet_a: assert property ($past(rst) |-> !irq && reg_rdata == 32'h0)
    else $error("outputs not quiet after reset");
  ctrl_zero_bits_a: assert property ($past(reg_read && reg_addr == 8'h00) |-> (reg_rdata & 32'hffff5c00) == 32'h0)
    else $error("unimplemented control bits set");
  unmapped_zero_a: assert property ($past(reg_read && reg_addr > 8'h10) |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  ctrl_echo_a: assert property (reg_write && reg_addr == 8'h00 ##1 reg_read && reg_addr == 8'h00
    |=> (reg_rdata & 32'h0000a3e7) == ($past(reg_wdata, 2) & 32'h0000a3e7)) else $error("control readback wrong");
  // Disable and interrupt gating
  flags_clear_a: assert property (reg_write && reg_addr == 8'h00 && !reg_wdata[15] ##1 !reg_write [*2]
    ##1 reg_read && reg_addr == 8'h00 |=> reg_rdata[4:3] == 2'h0) else $error("flags survive disable");
  off_irq_low_a: assert property (reg_write && reg_addr == 8'h00 && !reg_wdata[15] ##1 !reg_write |=> !irq)
    else $error("irq while disabled");
  mask_irq_low_a: assert property (reg_write && reg_addr == 8'h0c && reg_wdata[1:0] == 2'h0 ##1 !reg_write |=> !irq)
    else $error("irq while masked");
  irq_fall_cause_a: assert property ($fell(irq) |-> $past(reg_write) || $past(reg_write, 2))
    else $error("irq fell without a write");
endmodule // capture_checker

bind input_capture_control capture_checker capture_checker_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));

// ==== verification/tb.sv ====
`timescale 1ns/1ns
// ==========================================================
// Bench for the capture channel
module tb;
  reg         ref_clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  reg         idle_mode = 1'b0, tick = 1'b1, toggle = 1'b0;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [31:0] reg_wdata = 32'h0, cfg, e;
  wire [31:0] reg_rdata, wide_timebase;
  wire [15:0] first_timebase, second_timebase;
  wire        capture_pin, irq;
  integer     fails = 0, check_count = 0, cyc = 0, i, n;
  // Mode table: expected count, first edge, mode
  localparam [0:8][11:0] MT = {12'h000, 12'h201, 12'h102, 12'h103, 12'h004, 12'h005, 12'h216, 12'h106, 12'h107};

  input_capture_control input_capture_control_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .capture_pin(capture_pin), .idle_mode(idle_mode), .first_timebase(first_timebase),
    .second_timebase(second_timebase), .wide_timebase(wide_timebase), .irq(irq));
  capture_source capture_source_inst (.ref_clk(ref_clk), .rst(rst), .tick(tick), .toggle(toggle),
    .capture_pin(capture_pin), .first_timebase(first_timebase), .second_timebase(second_timebase),
    .wide_timebase(wide_timebase));

  // ==========================================================
  // Clock and hang guard
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      end_sim;
    end
  end

  // ==========================================================
  // Bus cycles and checks
  task bus(input w, input r, input [7:0] a, input [31:0] v);
    reg_write <= w;
    reg_read  <= r;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
  endtask
  task idle(input integer k);
    reg_write <= 1'b0;
    reg_read  <= 1'b0;
    repeat (k) @(posedge ref_clk);
  endtask
  task chk(input string nm, input [31:0] x, input [31:0] g);
    check_count = check_count + 1;
    if (g !== x) begin
      fails = fails + 1;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  // Read data sampled mid-cycle, while it stands; no race with the edge
  task rd(input [7:0] a, output [31:0] d);
    bus(1'b0, 1'b1, a, 32'h0);
    reg_read <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
    @(posedge ref_clk);
  endtask
  task rc(input [7:0] a, input [31:0] x, input string nm);
    reg [31:0] d;
    rd(a, d);
    chk(nm, x, d);
  endtask
  // Disable leaves two spare cycles before the next access
  task off;
    bus(1'b1, 1'b0, 8'h00, 32'h0);
    idle(2);
  endtask
  task tog;
    toggle <= 1'b1;
    idle(1);
    toggle <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // Drains the buffer while the not-empty flag is up
  task cnt(output integer k);
    reg [31:0] d;
    k = 0;
    repeat (5) begin
      rd(8'h00, d);
      chk("poll", 32'h0, d & 32'hffff5c00);
      if (d[3] === 1'b1) begin
        rd(8'h04, d);
        k = k + 1;
      end
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rc(8'h00, 32'h0, "control");
    rc(8'h08, 32'h0, "status");
    rc(8'h14, 32'h0, "unmapped");
    bus(1'b1, 1'b0, 8'h00, 32'hffffffff);
    rc(8'h00, 32'h0000a3e7, "control");
    off;
    for (i = 0; i < 3; i = i + 1) begin
      cfg = (i == 0) ? 32'h100 : (i == 1) ? 32'h80 : 32'h0;
      bus(1'b1, 1'b0, 8'h00, 32'h8003 | cfg);
      tick <= 1'b0;
      tog;
      e = (i == 0) ? wide_timebase : (i == 1) ? {16'h0, first_timebase} : {16'h0, second_timebase};
      rc(8'h00, 32'h800b | cfg, "control");
      rc(8'h04, e, "capture");
      tog;
      tick <= 1'b1;
      rc(8'h00, 32'h8003 | cfg, "control");
      off;
    end
    for (i = 0; i < 9; i = i + 1) begin
      bus(1'b1, 1'b0, 8'h00, 32'h8000 | (MT[i][7:4] << 9) | MT[i][3:0]);
      tog;
      tog;
      cnt(n);
      chk("captures", {28'h0, MT[i][11:8]}, n);
      off;
    end
    idle_mode <= 1'b1;
    for (i = 0; i < 2; i = i + 1) begin
      bus(1'b1, 1'b0, 8'h00, (i == 0) ? 32'ha001 : 32'h8001);
      tog;
      cnt(n);
      chk("idle captures", i, n);
      off;
    end
    idle_mode <= 1'b0;
    bus(1'b1, 1'b0, 8'h0c, 32'h1);
    for (i = 0; i < 4; i = i + 1) begin
      bus(1'b1, 1'b0, 8'h00, 32'h8001 | (i << 5));
      repeat (i) tog;
      chk("irq early", 32'h0, {31'h0, irq});
      tog;
      chk("irq", 32'h1, {31'h0, irq});
      rc(8'h08, 32'h1, "status");
      bus(1'b1, 1'b0, 8'h10, 32'h3);
      rc(8'h08, 32'h0, "status");
      chk("irq cleared", 32'h0, {31'h0, irq});
      off;
    end
    bus(1'b1, 1'b0, 8'h00, 32'h8001);
    repeat (5) tog;
    rc(8'h00, 32'h8019, "control");
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, 1'b0, 8'h0c, 32'h0);
    idle(2);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, 1'b0, 8'h0c, 32'h3);
    idle(2);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    off;
    chk("irq off", 32'h0, {31'h0, irq});
    rc(8'h00, 32'h0, "control");
    end_sim;
  end
endmodule // tb
